/* src/snoop_side_pkg.sv */
// constants shared by the sideband control block
package snoop_side_pkg;
   localparam int          DATA_W         = 64;
   localparam int          LANES          = 8;
   localparam int          INQ_START_DLY  = 2;
   localparam int          ADS_IGN_DLY    = 2;
   localparam int          BURST_BEATS    = 4;
   localparam int          FEAT_WRITE_BUFFER_EMPTY_INPUT_BIT  = 3;
   localparam logic [7:0]  FEAT_RESET     = 8'h00;
   localparam logic [1:0]  LINE_INVALID   = 2'h0;
   localparam logic [1:0]  LINE_SHARED    = 2'h1;
   localparam logic [1:0]  LINE_EXCLUSIVE = 2'h2;
   localparam logic [1:0]  LINE_MODIFIED  = 2'h3;
   typedef enum logic [2:0] {
      WB_IDLE = 3'b001,
      WB_WAIT = 3'b010,
      WB_BUSY = 3'b100
   } wb_state_t;
endpackage

/* src/pin_sync.sv */
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
module pin_sync #(
   parameter int          W        = 1,
   parameter logic [W-1:0] INIT    = '0
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rstn,
   // data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] meta_next;
   logic [W-1:0] q_next;

   always_comb begin
      meta_next = d;
      q_next    = meta_reg;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_reg <= INIT;
         q        <= INIT;
      end else begin
         meta_reg <= meta_next;
         q        <= q_next;
      end
   end
endmodule

/* src/bus_snoop_sideband_control.sv */
// sideband control: parity lines, inquire response, write buffer, fp error
// What this block does
// - single write: parity valid one edge after strobe, held until ready
// - writeback burst: parity after strobe, updated on each burst ready but the last, which floats the lines
// - reads capture parity lines on the edge ready is sampled
// - parity lines floated unless writing; float on backoff or grant
// - inquire strobe triggers lookup; report match and dirty match
// - inquire sampling starts two edges after yield, backoff or grant
// - inquire ignored after one, after strobe, while driving, while dirty
// - buffer not empty delays listed activities; bus cycles still finish
// - buffer-empty sampled on ready of writes other than writebacks, and of special cycles
// - once negated, sample every edge until asserted, then ignore
// - feature bit 3 set disables buffer-empty input entirely
// - fp error asserts at next fp instruction boundary, not at fault
// - fp error cleared by clear instructions, some loads, and reset
// - purge: write back dirty, invalidate all, then acknowledge cycle
// - purge request low at reset release selects three-state test mode
// - purge latched on falling edge, acted on at instruction boundary
// - test strap sampled on edge before reset is seen released
// - match flag for valid line; changes edge after strobe, then holds
// - dirty hit on line in writeback flags without a second writeback
// - dirty result after strobe; asserted one drops one edge after the last writeback burst ready
// - match, dirty match and fp error always driven except test mode
// - each parity bit gives even parity with its data byte
`timescale 1ns/10ps
module bus_snoop_sideband_control
   import snoop_side_pkg::*;
#(
   parameter int LW = snoop_side_pkg::LANES,
   parameter int DW = snoop_side_pkg::DATA_W
) (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          rstn,
   // core side bus cycle status
   input  wire logic          address_strobe,
   input  wire logic          cycle_write,
   input  wire logic          cycle_writeback,
   input  wire logic          cycle_special,
   input  wire logic          cycle_read,
   input  wire logic          driving_address,
   input  wire logic [DW-1:0] write_data,
   input  wire logic [DW-1:0] next_write_data,
   input  wire logic          takeover_grant_set,
   // core side events
   input  wire logic [1:0]    lookup_state,
   input  wire logic          line_in_writeback,
   input  wire logic          fp_boundary,
   input  wire logic          fp_fault,
   input  wire logic          fp_clear,
   input  wire logic [7:0]    extended_feature_control_register,
   input  wire logic          purge_done,
   // pins in
   input  wire logic          burst_ready_input_n,
   input  wire logic          backoff_request_n,
   input  wire logic          address_bus_yield_request,
   input  wire logic          inquire_address_strobe_n,
   input  wire logic          write_buffer_empty_input_n,
   input  wire logic          cache_purge_request_n,
   input  wire logic [LW-1:0] byte_parity_lines_in,
   // pins out
   output logic [LW-1:0]      byte_parity_lines_out,
   output logic               byte_parity_lines_oe_n,
   output logic               snoop_match_flag_n,
   output logic               snoop_match_flag_oe_n,
   output logic               snoop_dirty_match_flag_n,
   output logic               snoop_dirty_match_flag_oe_n,
   output logic               floating_point_error_output_n,
   output logic               floating_point_error_output_oe_n,
   // core side results
   output logic               inquire_lookup,
   output logic               writeback_request,
   output logic [LW-1:0]      read_parity,
   output logic               write_stall,
   output logic               purge_pending,
   output logic               test_mode
);
   function automatic logic [LW-1:0] even_par(input logic [DW-1:0] d);
      logic [LW-1:0] p;
      p = '0;
      for (int i = 0; i < LW; i++) begin
         p[i] = ^d[i*8 +: 8];
      end
      return p;
   endfunction

   // pins from the chipset domain
   logic burst_ready_input_s_n, backoff_request_s_n, address_bus_yield_request_s, inquire_address_strobe_s_n, write_buffer_empty_input_s_n, purge_s_n;
   pin_sync #(.W(6), .INIT(6'h35)) u_sync (
      .clk  (clk),
      .rstn (rstn),
      .d    ({burst_ready_input_n, backoff_request_n,
              address_bus_yield_request, inquire_address_strobe_n,
              write_buffer_empty_input_n, cache_purge_request_n}),
      .q    ({burst_ready_input_s_n, backoff_request_s_n, address_bus_yield_request_s, inquire_address_strobe_s_n, write_buffer_empty_input_s_n, purge_s_n})
   );
   logic [LW-1:0] rpar_s;
   pin_sync #(.W(LW)) u_psync (
      .clk  (clk),
      .rstn (rstn),
      .d    (byte_parity_lines_in),
      .q    (rpar_s)
   );

   logic burst_ready_input, backoff_request, inquire_address_strobe;
   assign burst_ready_input = !burst_ready_input_s_n;
   assign backoff_request = !backoff_request_s_n;
   assign inquire_address_strobe = !inquire_address_strobe_s_n;

   // state
   logic [LW-1:0] par_reg, par_next, rpar_reg, rpar_next;
   logic          par_oe_n_reg, par_oe_n_next;
   logic [1:0]    open_cnt_reg, open_cnt_next;
   logic          inq_open_reg, inq_open_next;
   logic          inquire_address_strobe_last_reg, inquire_address_strobe_last_next;
   logic [1:0]    ads_ign_reg, ads_ign_next;
   logic          hit_n_reg, hit_n_next, snoop_dirty_match_flag_n_reg, snoop_dirty_match_flag_n_next;
   logic          look_reg, look_next, wbreq_reg, wbreq_next;
   wb_state_t     wb_reg, wb_next;
   logic [2:0]    beats_reg, beats_next;
   logic          stall_reg, stall_next;
   logic          floating_point_error_output_pend_reg, floating_point_error_output_pend_next, floating_point_error_output_n_reg, floating_point_error_output_n_next;
   logic          purge_last_reg, purge_last_next;
   logic          purge_reg, purge_next;
   logic          strap_reg, strap_next, test_reg, test_next;
   logic          rel_reg, rel_next;
   logic          strap_meta_reg, strap_sync_reg;
   logic          yield_req, inquire_address_strobe_take, write_buffer_empty_input_off;

   assign yield_req = address_bus_yield_request_s || backoff_request || takeover_grant_set;
   // inquire accepted only when open and none of the blocking cases hold
   assign inquire_address_strobe_take = inquire_address_strobe && inq_open_reg && !inquire_address_strobe_last_reg
                      && (ads_ign_reg == 2'h0) && !driving_address
                      && snoop_dirty_match_flag_n_reg;
   assign write_buffer_empty_input_off  = extended_feature_control_register[FEAT_WRITE_BUFFER_EMPTY_INPUT_BIT];

   always_comb begin
      // parity lines
      par_next      = par_reg;
      par_oe_n_next = par_oe_n_reg;
      rpar_next     = rpar_reg;
      if (address_strobe && cycle_write) begin
         par_next      = even_par(write_data);
         par_oe_n_next = 1'b0;
      end else if (!par_oe_n_reg && burst_ready_input) begin
         if (cycle_writeback && beats_reg != 3'(BURST_BEATS - 1))
            par_next = even_par(next_write_data);
         else
            par_oe_n_next = 1'b1;
      end
      if (backoff_request || takeover_grant_set)
         par_oe_n_next = 1'b1;
      if (cycle_read && burst_ready_input)
         rpar_next = rpar_s;
      // inquire window
      open_cnt_next = open_cnt_reg;
      inq_open_next = inq_open_reg;
      if (!yield_req) begin
         open_cnt_next = 2'h0;
         inq_open_next = 1'b0;
      end else if (open_cnt_reg != 2'(INQ_START_DLY)) begin
         open_cnt_next = open_cnt_reg + 2'h1;
         inq_open_next = (open_cnt_reg == 2'(INQ_START_DLY - 1));
      end
      inquire_address_strobe_last_next = inquire_address_strobe_take;
      ads_ign_next   = address_strobe ? 2'(ADS_IGN_DLY)
                       : (ads_ign_reg != 2'h0 ? ads_ign_reg - 2'h1 : 2'h0);
      // lookup answer
      hit_n_next  = hit_n_reg;
      snoop_dirty_match_flag_n_next = snoop_dirty_match_flag_n_reg;
      look_next   = inquire_address_strobe_take;
      wbreq_next  = 1'b0;
      wb_next     = wb_reg;
      beats_next  = beats_reg;
      if (inquire_address_strobe_take) begin
         hit_n_next  = (lookup_state == LINE_INVALID);
         snoop_dirty_match_flag_n_next = (lookup_state != LINE_MODIFIED);
         if (lookup_state == LINE_MODIFIED) begin
            // a line already in flight is not written twice
            wbreq_next = !line_in_writeback;
            wb_next    = WB_WAIT;
         end
      end
      unique case (wb_reg)
         WB_IDLE: ;
         WB_WAIT: begin
            if (address_strobe && cycle_writeback) begin
               wb_next    = WB_BUSY;
               beats_next = 3'h0;
            end
         end
         WB_BUSY: begin
            if (burst_ready_input) begin
               beats_next = beats_reg + 3'h1;
               if (beats_reg == 3'(BURST_BEATS - 1)) begin
                  snoop_dirty_match_flag_n_next = 1'b1;
                  wb_next     = WB_IDLE;
               end
            end
         end
         default: wb_next = WB_IDLE;
      endcase
      if (!par_oe_n_reg && burst_ready_input && cycle_writeback && wb_reg != WB_BUSY)
         beats_next = beats_reg + 3'h1;
      if (address_strobe)
         beats_next = 3'h0;
      // write buffer flow control
      stall_next = stall_reg;
      if (write_buffer_empty_input_off)
         stall_next = 1'b0;
      else if (stall_reg)
         stall_next = write_buffer_empty_input_s_n;
      else if (burst_ready_input && (cycle_write || cycle_special) && !cycle_writeback)
         stall_next = write_buffer_empty_input_s_n;
      // floating point error; set at a boundary wins over clear
      floating_point_error_output_pend_next = (floating_point_error_output_pend_reg && !fp_boundary) || fp_fault;
      floating_point_error_output_n_next    = floating_point_error_output_n_reg;
      if (fp_clear)
         floating_point_error_output_n_next = 1'b1;
      if (floating_point_error_output_pend_reg && fp_boundary)
         floating_point_error_output_n_next = 1'b0;
      // purge request, falling edge latched, held until done
      purge_last_next = purge_s_n;
      purge_next      = (purge_reg && !purge_done)
                        || (purge_last_reg && !purge_s_n);
      // test strap: rel_reg marks the first edge after release
      rel_next   = 1'b1;
      strap_next = strap_reg;
      test_next  = test_reg;
      if (!rel_reg) begin
         strap_next = strap_sync_reg;
         test_next  = !strap_sync_reg;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         par_reg        <= '0;
         par_oe_n_reg   <= 1'b1;
         rpar_reg       <= '0;
         open_cnt_reg   <= 2'h0;
         inq_open_reg   <= 1'b0;
         inquire_address_strobe_last_reg  <= 1'b0;
         ads_ign_reg    <= 2'h0;
         hit_n_reg      <= 1'b1;
         snoop_dirty_match_flag_n_reg     <= 1'b1;
         look_reg       <= 1'b0;
         wbreq_reg      <= 1'b0;
         wb_reg         <= WB_IDLE;
         beats_reg      <= 3'h0;
         stall_reg      <= 1'b0;
         floating_point_error_output_pend_reg  <= 1'b0;
         floating_point_error_output_n_reg     <= 1'b1;
         purge_last_reg <= 1'b1;
         purge_reg      <= 1'b0;
         strap_reg      <= 1'b1;
         test_reg       <= 1'b0;
         rel_reg        <= 1'b0;
      end else begin
         par_reg        <= par_next;
         par_oe_n_reg   <= par_oe_n_next;
         rpar_reg       <= rpar_next;
         open_cnt_reg   <= open_cnt_next;
         inq_open_reg   <= inq_open_next;
         inquire_address_strobe_last_reg  <= inquire_address_strobe_last_next;
         ads_ign_reg    <= ads_ign_next;
         hit_n_reg      <= hit_n_next;
         snoop_dirty_match_flag_n_reg     <= snoop_dirty_match_flag_n_next;
         look_reg       <= look_next;
         wbreq_reg      <= wbreq_next;
         wb_reg         <= wb_next;
         beats_reg      <= beats_next;
         stall_reg      <= stall_next;
         floating_point_error_output_pend_reg  <= floating_point_error_output_pend_next;
         floating_point_error_output_n_reg     <= floating_point_error_output_n_next;
         purge_last_reg <= purge_last_next;
         purge_reg      <= purge_next;
         strap_reg      <= strap_next;
         test_reg       <= test_next;
         rel_reg        <= rel_next;
      end
   end

   // no reset here on purpose: the strap level during reset must get through
   always_ff @(posedge clk) begin
      strap_meta_reg <= cache_purge_request_n;
      strap_sync_reg <= strap_meta_reg;
   end

   // outputs straight from flops; test mode floats everything
   assign byte_parity_lines_out            = par_reg;
   assign byte_parity_lines_oe_n           = par_oe_n_reg | test_reg;
   assign snoop_match_flag_n               = hit_n_reg;
   assign snoop_match_flag_oe_n            = test_reg;
   assign snoop_dirty_match_flag_n         = snoop_dirty_match_flag_n_reg;
   assign snoop_dirty_match_flag_oe_n      = test_reg;
   assign floating_point_error_output_n    = floating_point_error_output_n_reg;
   assign floating_point_error_output_oe_n = test_reg;
   assign inquire_lookup                   = look_reg;
   assign writeback_request                = wbreq_reg;
   assign read_parity                      = rpar_reg;
   assign write_stall                      = stall_reg;
   assign purge_pending                    = purge_reg;
   assign test_mode                        = test_reg;
endmodule

/* sim/snoop_side_sva.sv */
// checker of the sideband control block port timing
`timescale 1ns/10ps
module snoop_side_sva #(
   parameter int LW = 8,
   parameter int DW = 64
) (
   // clock, reset and core side
   input wire logic          clk,
   input wire logic          rstn,
   input wire logic          address_strobe,
   input wire logic          cycle_write,
   input wire logic          cycle_writeback,
   input wire logic          driving_address,
   input wire logic [DW-1:0] write_data,
   input wire logic [1:0]    lookup_state,
   input wire logic          line_in_writeback,
   input wire logic          fp_boundary,
   // pins and results
   input wire logic [LW-1:0] byte_parity_lines_out,
   input wire logic          byte_parity_lines_oe_n,
   input wire logic          snoop_match_flag_n,
   input wire logic          snoop_match_flag_oe_n,
   input wire logic          snoop_dirty_match_flag_n,
   input wire logic          snoop_dirty_match_flag_oe_n,
   input wire logic          floating_point_error_output_n,
   input wire logic          floating_point_error_output_oe_n,
   input wire logic          inquire_lookup,
   input wire logic          writeback_request,
   input wire logic          test_mode
);
   import snoop_side_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   function automatic logic [LW-1:0] par(input logic [DW-1:0] d);
      for (int i = 0; i < LW; i++) par[i] = ^d[8*i +: 8];
   endfunction
   a_write_parity: assert property (
      address_strobe && cycle_write && !cycle_writeback |=>
      !byte_parity_lines_oe_n &&
      byte_parity_lines_out == par($past(write_data)))
      else $error("write parity wrong");
   a_match_change: assert property (
      !$stable(snoop_match_flag_n) |-> inquire_lookup)
      else $error("match flag moved without inquire");
   a_match_value: assert property (
      inquire_lookup |->
      snoop_match_flag_n == ($past(lookup_state) == LINE_INVALID))
      else $error("match flag value wrong");
   a_dirty_value: assert property (
      inquire_lookup |->
      snoop_dirty_match_flag_n == ($past(lookup_state) != LINE_MODIFIED) &&
      writeback_request == ($past(lookup_state) == LINE_MODIFIED &&
      !$past(line_in_writeback)))
      else $error("dirty flag or writeback wrong");
   a_inquire_spacing: assert property (
      inquire_lookup |=> !inquire_lookup)
      else $error("inquire taken on the next edge");
   a_dirty_blocks: assert property (
      !snoop_dirty_match_flag_n |=> !inquire_lookup)
      else $error("inquire taken while dirty flag set");
   a_driving_blocks: assert property (
      driving_address |=> !inquire_lookup)
      else $error("inquire taken while driving address");
   a_test_float: assert property (
      snoop_match_flag_oe_n == test_mode &&
      snoop_dirty_match_flag_oe_n == test_mode &&
      floating_point_error_output_oe_n == test_mode &&
      (!test_mode || byte_parity_lines_oe_n))
      else $error("output enables disagree with test mode");
   a_fp_at_boundary: assert property (
      $fell(floating_point_error_output_n) |-> $past(fp_boundary))
      else $error("fp error asserted off a boundary");
endmodule

/* sim/chipset_model.sv */
// chipset side pin model for the sideband block
`timescale 1ns/10ps
module chipset_model (
   // clock
   input  wire logic clk,
   // pins toward the device
   output logic       burst_ready_input_n,
   output logic       backoff_request_n,
   output logic       address_bus_yield_request,
   output logic       inquire_address_strobe_n,
   output logic       write_buffer_empty_input_n,
   output logic       cache_purge_request_n,
   output logic [7:0] byte_parity_lines_in
);
   initial begin
      {burst_ready_input_n, backoff_request_n, inquire_address_strobe_n} = 3'h7;
      {address_bus_yield_request, write_buffer_empty_input_n} = 2'h0;
      cache_purge_request_n = 1'b1;
      byte_parity_lines_in = 8'h00;
   end
   // parity only valid with ready; inverted after so stale data shows
   task automatic ready(input int waits, input logic [7:0] dp);
      repeat (waits + 1) @(posedge clk);
      burst_ready_input_n <= 1'b0;
      byte_parity_lines_in <= dp;
      @(posedge clk);
      burst_ready_input_n <= 1'b1;
      byte_parity_lines_in <= ~dp;
   endtask
   // callers take the address bus first
   task automatic inquire();
      @(posedge clk);
      inquire_address_strobe_n <= 1'b0;
      @(posedge clk);
      inquire_address_strobe_n <= 1'b1;
   endtask
   // asynchronous form: two clocks high, then two low
   task automatic purge();
      @(posedge clk);
      cache_purge_request_n <= 1'b1;
      repeat (2) @(posedge clk);
      cache_purge_request_n <= 1'b0;
      repeat (2) @(posedge clk);
      cache_purge_request_n <= 1'b1;
   endtask
endmodule

/* sim/bus_snoop_sideband_control_bench.sv */
// bench for the sideband control block
`timescale 1ns/10ps
module bus_snoop_sideband_control_bench;
   import snoop_side_pkg::*;
   logic        clk, rstn, address_strobe, cycle_write, cycle_writeback;
   logic        cycle_special, cycle_read, driving_address, purge_done;
   logic        takeover_grant_set, line_in_writeback, fp_fault, fp_clear;
   logic        fp_boundary, burst_ready_input_n, backoff_request_n;
   logic        address_bus_yield_request, inquire_address_strobe_n;
   logic        write_buffer_empty_input_n, cache_purge_request_n;
   logic        byte_parity_lines_oe_n, snoop_match_flag_n, test_mode;
   logic        snoop_match_flag_oe_n, snoop_dirty_match_flag_n;
   logic        snoop_dirty_match_flag_oe_n, floating_point_error_output_n;
   logic        floating_point_error_output_oe_n, inquire_lookup;
   logic        writeback_request, write_stall, purge_pending;
   logic [63:0] write_data, next_write_data;
   logic [1:0]  lookup_state;
   logic [7:0]  extended_feature_control_register, byte_parity_lines_in;
   logic [7:0]  byte_parity_lines_out, read_parity;
   int          bad_count, total_checks;
   chipset_model cm (.clk, .burst_ready_input_n, .backoff_request_n,
      .address_bus_yield_request, .inquire_address_strobe_n,
      .write_buffer_empty_input_n, .cache_purge_request_n,
      .byte_parity_lines_in);
   bus_snoop_sideband_control uut (.clk, .rstn, .address_strobe,
      .cycle_write, .cycle_writeback, .cycle_special, .cycle_read,
      .driving_address, .write_data, .next_write_data, .takeover_grant_set,
      .lookup_state, .line_in_writeback, .fp_boundary, .fp_fault, .fp_clear,
      .extended_feature_control_register, .purge_done, .burst_ready_input_n,
      .backoff_request_n, .address_bus_yield_request,
      .inquire_address_strobe_n, .write_buffer_empty_input_n,
      .cache_purge_request_n, .byte_parity_lines_in, .byte_parity_lines_out,
      .byte_parity_lines_oe_n, .snoop_match_flag_n, .snoop_match_flag_oe_n,
      .snoop_dirty_match_flag_n, .snoop_dirty_match_flag_oe_n,
      .floating_point_error_output_n, .floating_point_error_output_oe_n,
      .inquire_lookup, .writeback_request, .read_parity, .write_stall,
      .purge_pending, .test_mode);
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   function automatic logic [7:0] par(input logic [63:0] d);
      for (int i = 0; i < 8; i++) par[i] = ^d[8*i +: 8];
   endfunction
   function automatic logic pick(input int s);
      case (s)
         0: pick = byte_parity_lines_oe_n;
         1: pick = write_stall;
         2: pick = inquire_lookup;
         3: pick = snoop_dirty_match_flag_n;
         4: pick = floating_point_error_output_n;
         default: pick = purge_pending;
      endcase
   endfunction
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick();
      @(posedge clk);
      #1;
   endtask
   // bounded wait; running out ends the run
   task automatic await(input int s, input logic v);
      int n;
      for (n = 0; n < 20 && pick(s) !== v; n++) tick();
      total_checks++;
      if (n >= 20) begin
         bad_count++;
         $display("BAD %0t wait ran out on %0d", $time, s);
         summarize();
      end
   endtask
   task automatic strobe();
      @(posedge clk) address_strobe <= 1'b1;
      @(posedge clk) address_strobe <= 1'b0;
      #1;
   endtask
   // single write, buffer full meanwhile; mask sets feature bit 3
   task automatic t_write(input logic [63:0] d, input logic mask);
      @(posedge clk);
      extended_feature_control_register <= {4'h0, mask, 3'h0};
      write_data <= d;
      cycle_write <= 1'b1;
      cm.write_buffer_empty_input_n <= 1'b1;
      strobe();
      chk(byte_parity_lines_oe_n, 0);
      chk(byte_parity_lines_out, par(d));
      cm.ready(3, 8'h00);
      #1;
      chk(byte_parity_lines_out, par(d));
      await(0, 1);
      repeat (4) tick();
      chk(write_stall, !mask);
      @(posedge clk) cm.write_buffer_empty_input_n <= 1'b0;
      await(1, 0);
      @(posedge clk) cycle_write <= 1'b0;
   endtask
   task automatic t_read();
      @(posedge clk) cycle_read <= 1'b1;
      cm.ready(2, 8'h96);
      repeat (3) tick();
      chk(read_parity, 8'h96);
      @(posedge clk) cycle_read <= 1'b0;
   endtask
   task automatic t_inquire(input logic [1:0] st);
      @(posedge clk) lookup_state <= st;
      cm.address_bus_yield_request <= 1'b1;
      repeat (6) @(posedge clk);
      cm.inquire();
      await(2, 1);
      chk(snoop_match_flag_n, st == LINE_INVALID);
      chk(snoop_dirty_match_flag_n, st != LINE_MODIFIED);
      chk(writeback_request, st == LINE_MODIFIED);
      if (st == LINE_MODIFIED) begin
         @(posedge clk) cycle_writeback <= 1'b1;
         cycle_write <= 1'b1;
         next_write_data <= 64'h0102_0408_1020_4080;
         strobe();
         chk(byte_parity_lines_out, par(write_data));
         repeat (4) cm.ready(0, 8'h00);
         #1;
         chk(byte_parity_lines_out, par(next_write_data));
         chk(snoop_dirty_match_flag_n, 0);
         await(3, 1);
         chk(byte_parity_lines_oe_n, 1);
         @(posedge clk) cycle_writeback <= 1'b0;
         cycle_write <= 1'b0;
      end
      @(posedge clk) cm.address_bus_yield_request <= 1'b0;
   endtask
   task automatic quiet();
      for (int i = 0; i < 8; i++) begin
         tick();
         chk(inquire_lookup, 0);
      end
   endtask
   // strobe before the window opens, then while driving the address
   task automatic t_refused();
      @(posedge clk) cm.address_bus_yield_request <= 1'b1;
      cm.inquire_address_strobe_n <= 1'b0;
      @(posedge clk) cm.inquire_address_strobe_n <= 1'b1;
      quiet();
      @(posedge clk) driving_address <= 1'b1;
      cm.inquire();
      quiet();
      @(posedge clk) driving_address <= 1'b0;
      cm.address_bus_yield_request <= 1'b0;
   endtask
   task automatic t_fp();
      @(posedge clk) fp_fault <= 1'b1;
      @(posedge clk) fp_fault <= 1'b0;
      repeat (3) tick();
      chk(floating_point_error_output_n, 1);
      @(posedge clk) fp_boundary <= 1'b1;
      @(posedge clk) fp_boundary <= 1'b0;
      await(4, 0);
      @(posedge clk) fp_clear <= 1'b1;
      @(posedge clk) fp_clear <= 1'b0;
      await(4, 1);
   endtask
   task automatic t_purge();
      cm.purge();
      await(5, 1);
      @(posedge clk) purge_done <= 1'b1;
      @(posedge clk) purge_done <= 1'b0;
      await(5, 0);
   endtask
   task automatic t_reset(input logic strap);
      // raise fp error first so the reset clear is visible
      @(posedge clk) fp_fault <= 1'b1;
      @(posedge clk) fp_fault <= 1'b0;
      fp_boundary <= 1'b1;
      @(posedge clk) fp_boundary <= 1'b0;
      rstn <= 1'b0;
      cm.cache_purge_request_n <= strap;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) tick();
      chk(test_mode, !strap);
      chk(snoop_match_flag_oe_n, !strap);
      chk(floating_point_error_output_n, 1);
      @(posedge clk) cm.cache_purge_request_n <= 1'b1;
      repeat (3) @(posedge clk);
   endtask
   initial begin
      repeat (50000) @(posedge clk);
      await(0, 1'bx);
   end
   initial begin
      {rstn, address_strobe, cycle_write, cycle_writeback} = 4'h0;
      {cycle_special, cycle_read, driving_address, purge_done} = 4'h0;
      {takeover_grant_set, line_in_writeback, fp_fault} = 3'h0;
      {fp_clear, fp_boundary} = 2'h0;
      {write_data, next_write_data} = '0;
      lookup_state = LINE_INVALID;
      extended_feature_control_register = 8'h00;
      bad_count = 0;
      total_checks = 0;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      t_write(64'h0123_4567_89ab_cdef, 1'b0);
      t_write(64'hff00_0f1e_8000_7f01, 1'b1);
      t_read();
      for (int s = 0; s < 4; s++) t_inquire(s[1:0]);
      t_refused();
      t_fp();
      t_purge();
      t_reset(1'b0);
      t_reset(1'b1);
      summarize();
   end
endmodule
bind bus_snoop_sideband_control snoop_side_sva #(.LW(LW), .DW(DW)) sva_i (
   .clk, .rstn, .address_strobe, .cycle_write, .cycle_writeback,
   .driving_address, .write_data, .lookup_state, .line_in_writeback,
   .fp_boundary, .byte_parity_lines_out, .byte_parity_lines_oe_n,
   .snoop_match_flag_n, .snoop_match_flag_oe_n, .snoop_dirty_match_flag_n,
   .snoop_dirty_match_flag_oe_n, .floating_point_error_output_n,
   .floating_point_error_output_oe_n, .inquire_lookup, .writeback_request,
   .test_mode);
